// ==== pkg/lpw_pkg.sv ====
// Constants, types and register map of the low-power mode and wake controller.
// Assumes a single 10 MHz bus clock domain and an AHB-Lite register port.
package lpw_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int LPW_CLK_NS = 100;
	localparam int LPW_REC_LONG_CYC = 4096;
	localparam int LPW_REC_SHORT_CYC = 32;
	localparam logic [11:0] LPW_REC_LONG_LOAD = 12'hfff;
	localparam logic [11:0] LPW_REC_SHORT_LOAD = 12'h01f;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] LPW_CFG_OFS = 8'h00;
	localparam logic [7:0] LPW_CMD_OFS = 8'h04;
	localparam logic [7:0] LPW_STAT_OFS = 8'h08;
	localparam logic [7:0] LPW_VEC_OFS = 8'h0c;
	localparam logic [7:0] LPW_IRQEN_OFS = 8'h10;

	// Config field positions
	localparam int LPW_CFG_STOPEN = 0;
	localparam int LPW_CFG_OSCRUN = 1;
	localparam int LPW_CFG_SHORT_STOP_RECOVERY = 2;
	localparam int LPW_CFG_WDEN = 3;
	localparam int LPW_CFG_SMEN = 4;
	localparam int LPW_CFG_SMRST = 5;
	localparam int LPW_CFG_SMSTOP = 6;
	localparam int LPW_CFG_EXTMSK = 7;
	localparam int LPW_CFG_KBMSK = 8;
	localparam logic [8:0] LPW_CFG_RST = 9'h001;

	// Command bits
	localparam int LPW_CMD_WAIT = 0;
	localparam int LPW_CMD_STOP = 1;

	// ****************************************
	// Interrupt sources in priority order (index = bit of source vector)
	// ****************************************
	localparam int LPW_NSRC = 21;
	localparam int LPW_SRC_EXT = 0;
	localparam int LPW_SRC_BRK = 1;
	localparam int LPW_SRC_CGU = 2;
	localparam int LPW_SRC_T1OV = 3;
	localparam int LPW_SRC_T1C1 = 4;
	localparam int LPW_SRC_T1C0 = 5;
	localparam int LPW_SRC_T2OV = 6;
	localparam int LPW_SRC_T2C1 = 7;
	localparam int LPW_SRC_T2C0 = 8;
	localparam int LPW_SRC_SSTX = 9;
	localparam int LPW_SRC_SSRX = 10;
	localparam int LPW_SRC_ASTX = 11;
	localparam int LPW_SRC_ASRX = 12;
	localparam int LPW_SRC_ASER = 13;
	localparam int LPW_SRC_ADC = 14;
	localparam int LPW_SRC_TBM = 15;
	localparam int LPW_SRC_CNTX = 16;
	localparam int LPW_SRC_CNRX = 17;
	localparam int LPW_SRC_CNER = 18;
	localparam int LPW_SRC_CNWK = 19;
	localparam int LPW_SRC_KBD = 20;

	localparam logic [15:0] LPW_VEC_RESET = 16'hfffe;
	localparam logic [15:0] LPW_VEC_EXT = 16'hfffa;
	localparam logic [15:0] LPW_VEC_BRK = 16'hfffc;
	localparam logic [15:0] LPW_VEC_CGU = 16'hfff8;
	localparam logic [15:0] LPW_VEC_KBD = 16'hffe0;
	localparam logic [15:0] LPW_VEC_T1OV = 16'hfff2;
	localparam logic [15:0] LPW_VEC_T1C1 = 16'hfff4;
	localparam logic [15:0] LPW_VEC_T1C0 = 16'hfff6;
	localparam logic [15:0] LPW_VEC_T2OV = 16'hffec;
	localparam logic [15:0] LPW_VEC_T2C1 = 16'hffee;
	localparam logic [15:0] LPW_VEC_T2C0 = 16'hfff0;
	localparam logic [15:0] LPW_VEC_SSTX = 16'hffe8;
	localparam logic [15:0] LPW_VEC_SSRX = 16'hffea;
	localparam logic [15:0] LPW_VEC_ASTX = 16'hffe2;
	localparam logic [15:0] LPW_VEC_ASRX = 16'hffe4;
	localparam logic [15:0] LPW_VEC_ASER = 16'hffe6;
	localparam logic [15:0] LPW_VEC_ADC = 16'hffde;
	localparam logic [15:0] LPW_VEC_TBM = 16'hffdc;
	localparam logic [15:0] LPW_VEC_CNTX = 16'hffd4;
	localparam logic [15:0] LPW_VEC_CNRX = 16'hffd6;
	localparam logic [15:0] LPW_VEC_CNER = 16'hffd8;
	localparam logic [15:0] LPW_VEC_CNWK = 16'hffda;

	typedef enum logic [2:0]
	{
		LPW_RUN = 3'h0,
		LPW_WAIT = 3'h1,
		LPW_STOP = 3'h2,
		LPW_RECOVER = 3'h3,
		LPW_FETCH = 3'h4
	} lpw_state_t;

endpackage

// ==== rtl/lpw_ctrl.sv ====
// Low-power mode and wake controller: wait/stop sequencing, clock gating,
// peripheral freeze, wake request and vector selection.
// Assumes one clock hclk, AHB-Lite slave with hsel, wake sources on same clock,
// external interrupt and keyboard pins asynchronous.
// Recovery counted in hclk cycles; no separate oscillator clock domain.
// Pending pin requests are cleared only by the CPU vector fetch.
//
// Function
// - Wait clears interrupt mask, gates CPU clock; mask set only on reset exit.
// - Stop clears interrupt mask, gates CPU clock; mask set only on reset exit.
// - CPU clock stays off after stop until oscillator settle delay ends.
// - Oscillator-run bit clear: stop kills oscillator, loop, forces clocks low.
// - Oscillator-run bit set: stop kills the loop, oscillator keeps running.
// - Watchdog counts in wait and resets on timeout when enabled.
// - Stop removes watchdog clock and clears its prescaler.
// - Stop-enable bit decides whether the stop command is honoured.
// - External pin interrupt active in both modes; unmasked request wakes.
// - Keyboard interrupt active in both modes; unmasked request wakes.
// - Enabled supply monitor stays active in wait, in stop only with its stop bit set; with resets enabled it resets out.
// - Break, serial, timer, CAN units frozen in stop, registers kept.
// - Sync serial resumes after interrupt exit; reset exit from stop aborts and resets it.
// - Timer counters freeze in stop and continue after interrupt exit.
// - Timebase runs in stop only with oscillator kept alive.
// - In wait, CPU cannot reach timebase or CAN registers.
// - Reset-type exits from wait fetch from the reset vector pair.
// - External pin, break, clock generator interrupts use their own vectors.
// - Keyboard and timer one sources use their own vectors.
// - Timer two overflow, channel 1, channel 0 use their own vectors.
// - Sync and async serial sources use their own vectors.
// - Converter, timebase and four CAN sources use their own vectors.
// - Bus clock off in stop unless oscillator-run bit set.
// - Stop exit holds clocks off 4096 oscillator cycles.
// - Short-recovery bit shortens stop exit delay to 32 cycles.
`timescale 1ns/1ps
module lpw_ctrl
	import lpw_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ext_pin_irq_n,
	input wire logic [7:0] kbd_pins_n,
	input wire logic [LPW_NSRC-1:0] periph_irq,
	input wire logic supply_low,
	input wire logic watchdog_timeout,
	input wire logic cpu_vector_ack,
	output logic interrupt_mask,
	output logic cpu_clock_en,
	output logic bus_clock_en,
	output logic oscillator_en,
	output logic pll_en,
	output logic crystal_clock_out,
	output logic generator_output_clock,
	output logic generator_internal_clock,
	output logic watchdog_clock_input,
	output logic watchdog_prescaler_clr,
	output logic watchdog_unit_reset_en,
	output logic freeze_stop_units,
	output logic timebase_unit_run,
	output logic sync_serial_reset,
	output logic wait_reg_block,
	output logic system_reset,
	output logic vector_valid,
	output logic [15:0] vector_addr
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed
	{
		lpw_state_t st;
		logic [8:0] cfg;
		logic imask;
		logic [11:0] rec_cnt;
		logic rec_by_reset;
		logic [15:0] vec;
		logic vec_valid;
		logic sys_rst;
		logic ss_rst;
		logic [2:0] ext_sync;
		logic [2:0] kbd_sync;
		logic ext_stable;
		logic kbd_stable;
		logic ext_pend;
		logic kbd_pend;
		logic dp_act;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
		logic clkdiv;
	} lpw_regs_t;

	// Current and next copy of the whole state
	lpw_regs_t cur_ff;
	lpw_regs_t nxt_ff;

	// Vector lookup used by the wait and stop wake paths
	function automatic logic [15:0] lpw_vec_of(input logic [LPW_NSRC-1:0] src);
		logic [15:0] v;
		v = LPW_VEC_RESET;
		if (src[LPW_SRC_EXT]) v = LPW_VEC_EXT;
		else if (src[LPW_SRC_BRK]) v = LPW_VEC_BRK;
		else if (src[LPW_SRC_CGU]) v = LPW_VEC_CGU;
		else if (src[LPW_SRC_T1OV]) v = LPW_VEC_T1OV;
		else if (src[LPW_SRC_T1C1]) v = LPW_VEC_T1C1;
		else if (src[LPW_SRC_T1C0]) v = LPW_VEC_T1C0;
		else if (src[LPW_SRC_T2OV]) v = LPW_VEC_T2OV;
		else if (src[LPW_SRC_T2C1]) v = LPW_VEC_T2C1;
		else if (src[LPW_SRC_T2C0]) v = LPW_VEC_T2C0;
		else if (src[LPW_SRC_SSTX]) v = LPW_VEC_SSTX;
		else if (src[LPW_SRC_SSRX]) v = LPW_VEC_SSRX;
		else if (src[LPW_SRC_ASTX]) v = LPW_VEC_ASTX;
		else if (src[LPW_SRC_ASRX]) v = LPW_VEC_ASRX;
		else if (src[LPW_SRC_ASER]) v = LPW_VEC_ASER;
		else if (src[LPW_SRC_ADC]) v = LPW_VEC_ADC;
		else if (src[LPW_SRC_TBM]) v = LPW_VEC_TBM;
		else if (src[LPW_SRC_CNTX]) v = LPW_VEC_CNTX;
		else if (src[LPW_SRC_CNRX]) v = LPW_VEC_CNRX;
		else if (src[LPW_SRC_CNER]) v = LPW_VEC_CNER;
		else if (src[LPW_SRC_CNWK]) v = LPW_VEC_CNWK;
		else if (src[LPW_SRC_KBD]) v = LPW_VEC_KBD;
		return v;
	endfunction

	// Data-phase write hit on one register; shared by config and command paths
	function automatic logic lpw_wr_hit(input logic act, input logic wr, input logic [7:0] a,
		input logic [7:0] ofs);
		return act && wr && (a == ofs);
	endfunction

	// ****************************************
	// Combinational decode
	// ****************************************
	logic in_wait;
	logic in_stop;
	logic osc_run;
	logic [LPW_NSRC-1:0] wait_src;
	logic [LPW_NSRC-1:0] stop_src;
	logic reset_wake;
	logic ap_take;

	// Recovery counts as stop for gating and freeze
	assign in_wait = (cur_ff.st == LPW_WAIT);
	assign in_stop = (cur_ff.st == LPW_STOP) || (cur_ff.st == LPW_RECOVER);
	assign osc_run = cur_ff.cfg[LPW_CFG_OSCRUN];
	assign ap_take = hsel && hready && htrans[1];

	// Wake sources per mode; stop keeps only units that stay alive
	// Masked pins still latch pending; the mask only blocks the wake
	always_comb
	begin
		wait_src = periph_irq;
		wait_src[LPW_SRC_EXT] = cur_ff.ext_pend && !cur_ff.cfg[LPW_CFG_EXTMSK];
		wait_src[LPW_SRC_KBD] = cur_ff.kbd_pend && !cur_ff.cfg[LPW_CFG_KBMSK];
		stop_src = '0;
		stop_src[LPW_SRC_EXT] = wait_src[LPW_SRC_EXT];
		stop_src[LPW_SRC_KBD] = wait_src[LPW_SRC_KBD];
		stop_src[LPW_SRC_TBM] = periph_irq[LPW_SRC_TBM] && osc_run;
		stop_src[LPW_SRC_CNWK] = periph_irq[LPW_SRC_CNWK];
	end

	// Reset-class exits: watchdog only outside stop, monitor when enabled
	// Watchdog clock is removed in stop, so it cannot wake from there
	assign reset_wake = (watchdog_timeout && cur_ff.cfg[LPW_CFG_WDEN] && !in_stop)
		|| (supply_low && cur_ff.cfg[LPW_CFG_SMEN] && cur_ff.cfg[LPW_CFG_SMRST]
		&& (!in_stop || cur_ff.cfg[LPW_CFG_SMSTOP]));

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		nxt_ff = cur_ff;
		// Reset pulses last one cycle
		nxt_ff.sys_rst = 1'b0;
		nxt_ff.ss_rst = 1'b0;
		nxt_ff.clkdiv = ~cur_ff.clkdiv;
		// Pins: three flops, edge only when last two agree
		// Keyboard pins are ANDed first, so any one pin falling while the rest are high raises the request
		nxt_ff.ext_sync = {cur_ff.ext_sync[1:0], ext_pin_irq_n};
		nxt_ff.kbd_sync = {cur_ff.kbd_sync[1:0], &kbd_pins_n};
		if (cur_ff.ext_sync[2] == cur_ff.ext_sync[1])
		begin
			nxt_ff.ext_stable = cur_ff.ext_sync[2];
		end
		if (cur_ff.kbd_sync[2] == cur_ff.kbd_sync[1])
		begin
			nxt_ff.kbd_stable = cur_ff.kbd_sync[2];
		end
		// Falling edge latches a pending request; set beats ack clear
		if (cur_ff.st == LPW_FETCH && cpu_vector_ack)
		begin
			nxt_ff.ext_pend = 1'b0;
			nxt_ff.kbd_pend = 1'b0;
			nxt_ff.vec_valid = 1'b0;
		end
		if (cur_ff.ext_stable && !nxt_ff.ext_stable)
		begin
			nxt_ff.ext_pend = 1'b1;
		end
		if (cur_ff.kbd_stable && !nxt_ff.kbd_stable)
		begin
			nxt_ff.kbd_pend = 1'b1;
		end

		// Bus data phase write
		// Address phase is captured every cycle; only dp_act qualifies it
		nxt_ff.dp_act = ap_take;
		nxt_ff.dp_wr = hwrite;
		nxt_ff.dp_addr = haddr[7:0];
		if (lpw_wr_hit(cur_ff.dp_act, cur_ff.dp_wr, cur_ff.dp_addr, LPW_CFG_OFS))
		begin
			nxt_ff.cfg = hwdata[8:0];
		end

		unique case (cur_ff.st)
			LPW_RUN:
			begin
				if (lpw_wr_hit(cur_ff.dp_act, cur_ff.dp_wr, cur_ff.dp_addr, LPW_CMD_OFS))
				begin
					// Stop disabled: the wait bit of the same write still acts
					if (hwdata[LPW_CMD_STOP] && cur_ff.cfg[LPW_CFG_STOPEN])
					begin
						nxt_ff.st = LPW_STOP;
						nxt_ff.imask = 1'b0;
					end
					else if (hwdata[LPW_CMD_WAIT])
					begin
						nxt_ff.st = LPW_WAIT;
						nxt_ff.imask = 1'b0;
					end
				end
			end
			LPW_WAIT:
			begin
				if (reset_wake)
				begin
					nxt_ff.sys_rst = 1'b1;
					nxt_ff.imask = 1'b1;
					nxt_ff.vec = LPW_VEC_RESET;
					nxt_ff.vec_valid = 1'b1;
					nxt_ff.st = LPW_FETCH;
				end
				else if (|wait_src)
				begin
					nxt_ff.vec = lpw_vec_of(wait_src);
					nxt_ff.vec_valid = 1'b1;
					nxt_ff.st = LPW_FETCH;
				end
			end
			LPW_STOP:
			begin
				// Reset beats interrupt so a reset exit never takes an interrupt vector
				if (reset_wake || |stop_src)
				begin
					nxt_ff.rec_by_reset = reset_wake;
					nxt_ff.vec = reset_wake ? LPW_VEC_RESET : lpw_vec_of(stop_src);
					nxt_ff.rec_cnt = cur_ff.cfg[LPW_CFG_SHORT_STOP_RECOVERY] ? LPW_REC_SHORT_LOAD
						: LPW_REC_LONG_LOAD;
					nxt_ff.st = LPW_RECOVER;
				end
			end
			LPW_RECOVER:
			begin
				// Clocks held off until settle count expires
				if (cur_ff.rec_cnt == '0)
				begin
					nxt_ff.vec_valid = 1'b1;
					nxt_ff.st = LPW_FETCH;
					if (cur_ff.rec_by_reset)
					begin
						nxt_ff.sys_rst = 1'b1;
						nxt_ff.ss_rst = 1'b1;
						nxt_ff.imask = 1'b1;
					end
				end
				else
				begin
					nxt_ff.rec_cnt = cur_ff.rec_cnt - 12'h001;
				end
			end
			LPW_FETCH:
			begin
				// Vector stands until the CPU has fetched it
				if (cpu_vector_ack)
				begin
					nxt_ff.st = LPW_RUN;
				end
			end
			default:
			begin
				nxt_ff.st = LPW_RUN;
			end
		endcase

		// Read data for next data phase
		// Status is sampled at the address phase, one cycle before it is seen
		nxt_ff.rdata = '0;
		if (ap_take && !hwrite)
		begin
			unique case (haddr[7:0])
				LPW_CFG_OFS: nxt_ff.rdata = {23'h000000, cur_ff.cfg};
				LPW_STAT_OFS: nxt_ff.rdata = {25'h0000000, cur_ff.kbd_pend,
					cur_ff.ext_pend, cur_ff.imask, 1'b0, cur_ff.st};
				LPW_VEC_OFS: nxt_ff.rdata = {15'h0000, cur_ff.vec_valid, cur_ff.vec};
				LPW_IRQEN_OFS: nxt_ff.rdata = {11'h000, periph_irq};
				default: nxt_ff.rdata = '0;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// One register for the whole state; reset loads constants only
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cur_ff <= '{st: LPW_RUN, cfg: LPW_CFG_RST, imask: 1'b1, rec_cnt: 12'h000,
				rec_by_reset: 1'b0, vec: LPW_VEC_RESET, vec_valid: 1'b0, sys_rst: 1'b0,
				ss_rst: 1'b0, ext_sync: 3'h7, kbd_sync: 3'h7, ext_stable: 1'b1,
				kbd_stable: 1'b1, ext_pend: 1'b0, kbd_pend: 1'b0, dp_act: 1'b0,
				dp_wr: 1'b0, dp_addr: 8'h00, rdata: 32'h00000000, clkdiv: 1'b0};
		end
		else
		begin
			cur_ff <= nxt_ff;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Zero-wait slave, always OKAY
	// No wait states: every register answers in the data phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = cur_ff.rdata;

	// Clock gating; full stop kills the oscillator and its derived clocks
	// Recovery keeps the stop gating, trading a slower restart for a clean one
	assign cpu_clock_en = (cur_ff.st == LPW_RUN) || (cur_ff.st == LPW_FETCH);
	assign bus_clock_en = !in_stop || osc_run;
	assign oscillator_en = !in_stop || osc_run;
	assign pll_en = !in_stop;
	assign crystal_clock_out = oscillator_en && cur_ff.clkdiv;
	assign generator_output_clock = pll_en && cur_ff.clkdiv;
	assign generator_internal_clock = pll_en && cur_ff.clkdiv;
	assign watchdog_clock_input = !in_stop;
	assign watchdog_prescaler_clr = in_stop;
	assign watchdog_unit_reset_en = cur_ff.cfg[LPW_CFG_WDEN] && !in_stop;
	assign freeze_stop_units = in_stop;
	assign timebase_unit_run = !in_stop || osc_run;
	assign sync_serial_reset = cur_ff.ss_rst;
	assign wait_reg_block = in_wait;
	assign system_reset = cur_ff.sys_rst;
	assign interrupt_mask = cur_ff.imask;
	assign vector_valid = cur_ff.vec_valid;
	assign vector_addr = cur_ff.vec;

endmodule

// ==== tb/lpw_chk.sv ====
// Checker: timing relations on the wake controller outputs.
// Bound into lpw_ctrl; one clock hclk, async active-low hresetn.
`timescale 1ns/1ps
module lpw_chk
	import lpw_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic watchdog_timeout,
	input wire logic cpu_vector_ack,
	input wire logic interrupt_mask,
	input wire logic cpu_clock_en,
	input wire logic bus_clock_en,
	input wire logic oscillator_en,
	input wire logic pll_en,
	input wire logic crystal_clock_out,
	input wire logic generator_output_clock,
	input wire logic generator_internal_clock,
	input wire logic watchdog_clock_input,
	input wire logic watchdog_prescaler_clr,
	input wire logic watchdog_unit_reset_en,
	input wire logic freeze_stop_units,
	input wire logic timebase_unit_run,
	input wire logic wait_reg_block,
	input wire logic system_reset,
	input wire logic vector_valid,
	input wire logic [15:0] vector_addr
);
	// ****************************************
	// Helpers and properties
	// ****************************************
	logic cmd_ff;
	logic [12:0] rec_ff;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Command address phase; frozen cycles, saturating, cleared when running
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cmd_ff <= 1'b0;
			rec_ff <= '0;
		end
		else
		begin
			cmd_ff <= hsel && htrans[1] && hwrite && haddr[7:0] == LPW_CMD_OFS;
			rec_ff <= !freeze_stop_units ? 13'h0 : rec_ff + {12'h0, ~&rec_ff};
		end
	end
	property p_cmd_gate;
		cmd_ff && hwdata[1:0] != 2'h0 |=> !cpu_clock_en && !interrupt_mask;
	endproperty
	a_cmd_gate: assert property (p_cmd_gate) else $error("clock or mask left on");
	property p_osc_off;
		!oscillator_en |-> !pll_en && !crystal_clock_out && !generator_output_clock
			&& !generator_internal_clock;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("clock out while osc off");
	property p_stop_clk;
		watchdog_prescaler_clr |-> !pll_en && !watchdog_clock_input
			&& (oscillator_en || !bus_clock_en);
	endproperty
	a_stop_clk: assert property (p_stop_clk) else $error("clock on in stop");
	property p_tbm;
		timebase_unit_run && watchdog_prescaler_clr |-> oscillator_en;
	endproperty
	a_tbm: assert property (p_tbm) else $error("timebase runs with osc off");
	property p_wait_blk;
		wait_reg_block |-> !cpu_clock_en && bus_clock_en;
	endproperty
	a_wait_blk: assert property (p_wait_blk) else $error("wait clocks wrong");
	property p_wd_rst;
		watchdog_timeout && watchdog_unit_reset_en && wait_reg_block |-> ##[1:2] system_reset;
	endproperty
	a_wd_rst: assert property (p_wd_rst) else $error("no watchdog reset");
	property p_rst_vec;
		system_reset |-> ##[0:1] (vector_valid && vector_addr == LPW_VEC_RESET && interrupt_mask);
	endproperty
	a_rst_vec: assert property (p_rst_vec) else $error("reset exit vector wrong");
	property p_vec_hold;
		vector_valid && !cpu_vector_ack |=> vector_valid && $stable(vector_addr);
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector dropped early");
	property p_rec_len;
		// Stop time adds to recovery: at least one stop cycle plus the short count
		$fell(freeze_stop_units) |-> rec_ff >= 13'd33;
	endproperty
	a_rec_len: assert property (p_rec_len) else $error("recovery length wrong");
	property p_frz_cpu;
		freeze_stop_units |-> !cpu_clock_en;
	endproperty
	a_frz_cpu: assert property (p_frz_cpu) else $error("cpu clock before settle");
endmodule

// ==== tb/lpw_src.sv ====
// Interrupt sources and CPU vector fetch facing the wake controller.
// Driven by tb through go/idx; acks a valid vector after dly cycles.
`timescale 1ns/1ps
module lpw_src
	import lpw_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go,
	input wire logic [4:0] idx,
	input wire logic [3:0] dly,
	input wire logic vector_valid,
	output logic ext_pin_irq_n,
	output logic [7:0] kbd_pins_n,
	output logic [LPW_NSRC-1:0] periph_irq,
	output logic cpu_vector_ack
);
	logic [3:0] cnt;
	// Hold the request until the vector is taken; pins idle high on pull-ups
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ext_pin_irq_n <= 1'b1;
			kbd_pins_n <= 8'hff;
			periph_irq <= '0;
			cpu_vector_ack <= 1'b0;
			cnt <= 4'h0;
		end
		else
		begin
			cpu_vector_ack <= 1'b0;
			if (go && idx == 5'd0)
				ext_pin_irq_n <= 1'b0;
			else if (go && idx == 5'd20)
				kbd_pins_n <= 8'hfe;
			else if (go && idx < 5'd20)
				periph_irq[idx] <= 1'b1;
			if (vector_valid && !cpu_vector_ack)
				cnt <= cnt + 4'h1;
			// Release with the ack so no stale level re-arms a wake
			if (vector_valid && !cpu_vector_ack && cnt == dly)
			begin
				cpu_vector_ack <= 1'b1;
				cnt <= 4'h0;
				ext_pin_irq_n <= 1'b1;
				kbd_pins_n <= 8'hff;
				periph_irq <= '0;
			end
		end
	end
endmodule

// ==== tb/tb.sv ====
// Bench: AHB-Lite register tasks, wait/stop entry and wake scenarios.
// Assumes lpw_ctrl, lpw_src, lpw_chk compiled; hready looped from hreadyout.
`timescale 1ns/1ps
bind lpw_ctrl lpw_chk i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.watchdog_timeout, .cpu_vector_ack, .interrupt_mask, .cpu_clock_en, .bus_clock_en,
	.oscillator_en, .pll_en, .crystal_clock_out, .generator_output_clock,
	.generator_internal_clock, .watchdog_clock_input, .watchdog_prescaler_clr,
	.watchdog_unit_reset_en, .freeze_stop_units, .timebase_unit_run, .wait_reg_block,
	.system_reset, .vector_valid, .vector_addr);
module tb
	import lpw_pkg::*;
;
	// ****************************************
	// Signals, design and partner
	// ****************************************
	localparam logic [15:0] vt [LPW_NSRC] = '{LPW_VEC_EXT, LPW_VEC_BRK, LPW_VEC_CGU,
		LPW_VEC_T1OV, LPW_VEC_T1C1, LPW_VEC_T1C0, LPW_VEC_T2OV, LPW_VEC_T2C1, LPW_VEC_T2C0,
		LPW_VEC_SSTX, LPW_VEC_SSRX, LPW_VEC_ASTX, LPW_VEC_ASRX, LPW_VEC_ASER, LPW_VEC_ADC,
		LPW_VEC_TBM, LPW_VEC_CNTX, LPW_VEC_CNRX, LPW_VEC_CNER, LPW_VEC_CNWK, LPW_VEC_KBD};
	logic hclk = 1'b0;
	logic hresetn = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, go = 1'b0, supply_low = 1'b0, watchdog_timeout = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
	logic [1:0] htrans = '0;
	logic [4:0] idx = '0;
	logic [3:0] dly = '0;
	logic hreadyout, hresp, ext_pin_irq_n, cpu_vector_ack, interrupt_mask, cpu_clock_en;
	logic bus_clock_en, oscillator_en, pll_en, crystal_clock_out, generator_output_clock;
	logic generator_internal_clock, watchdog_clock_input, watchdog_prescaler_clr;
	logic watchdog_unit_reset_en, freeze_stop_units, timebase_unit_run, sync_serial_reset;
	logic wait_reg_block, system_reset, vector_valid;
	logic [7:0] kbd_pins_n;
	logic [LPW_NSRC-1:0] periph_irq;
	logic [15:0] vector_addr;
	int failures = 0, total_checks = 0, ssr = 0;
	lpw_ctrl i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_pin_irq_n, .kbd_pins_n,
		.periph_irq, .supply_low, .watchdog_timeout, .cpu_vector_ack, .interrupt_mask,
		.cpu_clock_en, .bus_clock_en, .oscillator_en, .pll_en, .crystal_clock_out,
		.generator_output_clock, .generator_internal_clock, .watchdog_clock_input,
		.watchdog_prescaler_clr, .watchdog_unit_reset_en, .freeze_stop_units,
		.timebase_unit_run, .sync_serial_reset, .wait_reg_block, .system_reset,
		.vector_valid, .vector_addr);
	lpw_src i_src (.hclk, .hresetn, .go, .idx, .dly, .vector_valid, .ext_pin_irq_n,
		.kbd_pins_n, .periph_irq, .cpu_vector_ack);
	// Clock and sync-serial reset pulse count
	always #50 hclk = ~hclk;
	always @(posedge hclk)
		if (sync_serial_reset === 1'b1)
			ssr++;
	// ****************************************
	// Tasks
	// ****************************************
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			failures++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Single transfer; both phases wait for hready
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		chk(r, e);
	endtask
	// Optional command, one source event, then vector and wake delay
	task wake(input logic [1:0] cmd, input logic [4:0] s, input int lo, input logic [15:0] v);
		int n;
		n = 0;
		if (cmd != 2'h0)
			ahb(1'b1, LPW_CMD_OFS, {30'h0, cmd});
		idx <= s;
		go <= 1'b1;
		supply_low <= s == 5'd30;
		watchdog_timeout <= s == 5'd31;
		@(posedge hclk);
		go <= 1'b0;
		supply_low <= 1'b0;
		watchdog_timeout <= 1'b0;
		while (vector_valid !== 1'b1 && n < 5000)
		begin
			@(posedge hclk);
			n++;
		end
		chk({31'h0, n >= lo && n <= lo + 14}, 32'h1);
		chk({16'h0, vector_addr}, {16'h0, v});
		repeat (20) @(posedge hclk);
	endtask
	task tend(input string s);
		$display("test %s done: %0d checks %0d failures", s, total_checks, failures);
	endtask
	task final_report();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		hresetn <= 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(LPW_CFG_OFS, 32'h1);
		rd(LPW_STAT_OFS, 32'h10);
		rd(LPW_VEC_OFS, 32'hfffe);
		rd(8'h20, 32'h0);
		tend("reset");
		for (int i = 0; i < LPW_NSRC; i++)
		begin
			dly <= i[3:0];
			wake(2'h1, i[4:0], 0, vt[i]);
			rd(LPW_STAT_OFS, 32'h0);
		end
		tend("wait vectors");
		// Masked pin must not wake; keyboard still does
		ahb(1'b1, LPW_CFG_OFS, 32'h81);
		ahb(1'b1, LPW_CMD_OFS, 32'h1);
		idx <= 5'd0;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		repeat (30) @(posedge hclk);
		chk({vector_valid, wait_reg_block}, 32'h1);
		wake(2'h0, 5'd20, 0, LPW_VEC_KBD);
		tend("mask");
		ahb(1'b1, LPW_CFG_OFS, 32'h9);
		wake(2'h1, 5'd31, 0, LPW_VEC_RESET);
		rd(LPW_STAT_OFS, 32'h10);
		ahb(1'b1, LPW_CFG_OFS, 32'h31);
		wake(2'h1, 5'd30, 0, LPW_VEC_RESET);
		ahb(1'b1, LPW_CFG_OFS, 32'h71);
		wake(2'h2, 5'd30, 4096, LPW_VEC_RESET);
		rd(LPW_STAT_OFS, 32'h10);
		chk(ssr, 32'h1);
		tend("reset exits");
		// Full stop: oscillator, loop, bus and watchdog clocks all off
		ahb(1'b1, LPW_CFG_OFS, 32'h1);
		ahb(1'b1, LPW_CMD_OFS, 32'h2);
		@(posedge hclk);
		chk({oscillator_en, pll_en, bus_clock_en, watchdog_clock_input}, 32'h0);
		wake(2'h0, 5'd0, 4096, LPW_VEC_EXT);
		rd(LPW_STAT_OFS, 32'h0);
		ahb(1'b1, LPW_CFG_OFS, 32'h7);
		ahb(1'b1, LPW_CMD_OFS, 32'h2);
		@(posedge hclk);
		chk({oscillator_en, pll_en, timebase_unit_run, freeze_stop_units}, 32'hb);
		wake(2'h0, 5'd20, 32, LPW_VEC_KBD);
		wake(2'h2, 5'd15, 32, LPW_VEC_TBM);
		tend("stop");
		// Stop disabled: only the wait bit of the command acts
		ahb(1'b1, LPW_CFG_OFS, 32'h0);
		ahb(1'b1, LPW_CMD_OFS, 32'h3);
		rd(LPW_STAT_OFS, 32'h1);
		wake(2'h0, 5'd3, 0, LPW_VEC_T1OV);
		tend("stop disabled");
		final_report();
	end
	// Whole run is about 9k cycles; cut a hang at 30k
	initial
	begin
		#3ms;
		failures++;
		final_report();
	end
endmodule
